// ===== hw/oscsw_decode.sv
`include "oscsw_defs.svh"

module oscsw_decode
	import oscsw_pkg::*;
(
	oscsw_sel_if.dec sel
);
	always_comb begin
		case (sel.src_code)
			OSCSW_SRC_RSV0,
			OSCSW_SRC_RSV3: sel.src_eff = OSCSW_SRC_HF;
			default:        sel.src_eff = sel.src_code;
		endcase
	end

	assign sel.div_rsv = sel.div_code > `OSCSW_DIV_MAX;

	genvar g;
	generate
		for (g = 0; g < 10; g = g + 1) begin : g_div
			assign sel.div_onehot[g] = (sel.div_code == 4'(g));
		end
	endgenerate
endmodule // oscsw_decode

// ===== hw/oscsw_defs.svh
`ifndef OSCSW_DEFS_SVH
`define OSCSW_DEFS_SVH

// Register offsets on the plain port
`define OSCSW_ADDR_REQ      4'h0
`define OSCSW_ADDR_CUR      4'h1
`define OSCSW_ADDR_STAT     4'h2
`define OSCSW_ADDR_FREQ     4'h3
`define OSCSW_ADDR_IRQ_STAT 4'h4
`define OSCSW_ADDR_IRQ_MASK 4'h5

// Field positions in the status/control register
`define OSCSW_BIT_HOLD      7
`define OSCSW_BIT_SECONDARY_OSC_POWER   6
`define OSCSW_BIT_DONE      4
`define OSCSW_BIT_NEWRDY    3

// Field positions in the requested/current clock registers
`define OSCSW_SRC_MSB       6
`define OSCSW_SRC_LSB       4
`define OSCSW_DIV_MSB       3
`define OSCSW_DIV_LSB       0

// Interrupt status bits
`define OSCSW_IRQ_HELD      0
`define OSCSW_IRQ_DONE      1

// Reset value and largest valid divider code
`define OSCSW_RST_REG       8'h00
`define OSCSW_DIV_MAX       4'h9

`endif

// ===== hw/oscsw_pkg.sv
package oscsw_pkg;
	typedef enum logic [2:0] {
		OSCSW_SRC_RSV0    = 3'h0,
		OSCSW_SRC_HFPLL   = 3'h1,
		OSCSW_SRC_EXTPLL  = 3'h2,
		OSCSW_SRC_RSV3    = 3'h3,
		OSCSW_SRC_SEC     = 3'h4,
		OSCSW_SRC_LF      = 3'h5,
		OSCSW_SRC_HF      = 3'h6,
		OSCSW_SRC_EXT     = 3'h7
	} oscsw_src_t;

	typedef enum {
		OSCSW_IDLE,
		OSCSW_WAIT,
		OSCSW_HELD
	} oscsw_state_t;
endpackage

// ===== hw/oscsw_sel_if.sv
interface oscsw_sel_if;
	logic [2:0] src_code;
	logic [3:0] div_code;
	logic [2:0] src_eff;
	logic [9:0] div_onehot;
	logic       div_rsv;

	modport dec (input src_code, input div_code, output src_eff, output div_onehot,
		output div_rsv);
	modport user (output src_code, output div_code, input src_eff, input div_onehot,
		input div_rsv);
endinterface

// ===== hw/oscsw_top.sv
// The placing of the registers and strobed register access were left to the implementer.
`include "oscsw_defs.svh"

module oscsw_top
	import oscsw_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_osc_ready,
	input  wire logic [2:0] i_external_osc_mode_cfg,
	output logic      [7:0] o_rdata,
	output logic      [7:0] o_osc_enable,
	output logic      [2:0] o_sys_src,
	output logic      [9:0] o_sys_div,
	output logic      [3:0] o_fast_internal_freq_select,
	output logic      [2:0] o_external_mode,
	output logic            o_secondary_osc_power,
	output logic            o_irq
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0]   requested_clock_reg_r;
	logic [7:0]   current_clock_reg_r;
	logic [7:0]   internal_freq_reg_r;
	logic         switch_hold_r;
	logic         secondary_osc_power_r;
	logic [1:0]   irq_stat_r;
	logic [1:0]   irq_mask_r;
	logic [1:0]   irq_set;
	oscsw_state_t state_r;
	logic         new_rdy;
	logic         do_switch;
	logic         switch_busy;
	logic [7:0]   stat_val;
	logic [7:0]   rdata_nxt;

	wire wr_req  = i_wr && (i_addr == `OSCSW_ADDR_REQ);
	wire wr_stat = i_wr && (i_addr == `OSCSW_ADDR_STAT);
	wire wr_freq = i_wr && (i_addr == `OSCSW_ADDR_FREQ);
	wire wr_mask = i_wr && (i_addr == `OSCSW_ADDR_IRQ_MASK);
	wire rd_irq  = i_rd && (i_addr == `OSCSW_ADDR_IRQ_STAT);

	// ------------------------------------------------------------
	// Decoders
	// ------------------------------------------------------------
	oscsw_sel_if req_sel ();
	oscsw_sel_if cur_sel ();

	assign req_sel.src_code = requested_clock_reg_r[`OSCSW_SRC_MSB:`OSCSW_SRC_LSB];
	assign req_sel.div_code = requested_clock_reg_r[`OSCSW_DIV_MSB:`OSCSW_DIV_LSB];
	assign cur_sel.src_code = current_clock_reg_r[`OSCSW_SRC_MSB:`OSCSW_SRC_LSB];
	assign cur_sel.div_code = current_clock_reg_r[`OSCSW_DIV_MSB:`OSCSW_DIV_LSB];

	oscsw_decode u_req_dec (
		.sel (req_sel)
	);
	oscsw_decode u_cur_dec (
		.sel (cur_sel)
	);

	// ------------------------------------------------------------
	// Switch sequencing
	// ------------------------------------------------------------
	// busy while selections differ
	assign switch_busy = (requested_clock_reg_r != current_clock_reg_r);
	assign new_rdy = switch_busy && i_osc_ready[req_sel.src_eff];
	assign do_switch = new_rdy && !switch_hold_r;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= OSCSW_IDLE;
		end else begin
			case (state_r)
				OSCSW_IDLE: begin
					if (switch_busy) begin
						state_r <= OSCSW_WAIT;
					end
				end
				OSCSW_WAIT: begin
					if (!switch_busy || do_switch) begin
						state_r <= OSCSW_IDLE;
					end else if (new_rdy) begin
						state_r <= OSCSW_HELD;
					end
				end
				OSCSW_HELD: begin
					if (!switch_busy || do_switch) begin
						state_r <= OSCSW_IDLE;
					end
				end
				default: state_r <= OSCSW_IDLE;
			endcase
		end
	end

	// Held event fires once on entry, so a long hold gives one interrupt
	// hold raises interrupt
	assign irq_set[`OSCSW_IRQ_HELD] = (state_r == OSCSW_WAIT) && new_rdy && switch_hold_r;
	assign irq_set[`OSCSW_IRQ_DONE] = do_switch;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			requested_clock_reg_r <= `OSCSW_RST_REG;
		end else if (wr_req) begin
			requested_clock_reg_r <= {1'b0, i_wdata[6:0]};
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			current_clock_reg_r <= `OSCSW_RST_REG;
		end else if (do_switch) begin
			current_clock_reg_r <= requested_clock_reg_r;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			internal_freq_reg_r <= `OSCSW_RST_REG;
		end else if (wr_freq) begin
			internal_freq_reg_r <= {4'h0, i_wdata[3:0]};
		end
	end

	// hold bit, no hardware clear here
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			switch_hold_r <= 1'b0;
		end else if (wr_stat) begin
			switch_hold_r <= i_wdata[`OSCSW_BIT_HOLD];
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			secondary_osc_power_r <= 1'b0;
		end else if (wr_stat) begin
			secondary_osc_power_r <= i_wdata[`OSCSW_BIT_SECONDARY_OSC_POWER];
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Set wins over the read clear
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_r <= 2'h0;
		end else if (rd_irq) begin
			irq_stat_r <= irq_set;
		end else begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_r <= 2'h0;
		end else if (wr_mask) begin
			irq_mask_r <= i_wdata[1:0];
		end
	end

	// ------------------------------------------------------------
	// Status view
	// ------------------------------------------------------------
	// unimplemented bits zero
	always_comb begin
		stat_val = 8'h00;
		stat_val[`OSCSW_BIT_HOLD]    = switch_hold_r;
		stat_val[`OSCSW_BIT_SECONDARY_OSC_POWER] = secondary_osc_power_r;
		stat_val[`OSCSW_BIT_DONE]    = !switch_busy;
		stat_val[`OSCSW_BIT_NEWRDY]  = new_rdy;
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		rdata_nxt = 8'h00;
		if (i_rd) begin
			case (i_addr)
				`OSCSW_ADDR_REQ:      rdata_nxt = requested_clock_reg_r;
				`OSCSW_ADDR_CUR:      rdata_nxt = current_clock_reg_r;
				`OSCSW_ADDR_STAT:     rdata_nxt = stat_val;
				`OSCSW_ADDR_FREQ:     rdata_nxt = internal_freq_reg_r;
				`OSCSW_ADDR_IRQ_STAT: rdata_nxt = {6'h00, irq_stat_r};
				`OSCSW_ADDR_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
				default:              rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Clock control outputs
	// ------------------------------------------------------------
	// Both current and requested kept running across a switch
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_osc_enable <= 8'h00;
		end else begin
			o_osc_enable <= (8'h01 << cur_sel.src_eff) | (8'h01 << req_sel.src_eff);
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_sys_src <= 3'h0;
		end else begin
			o_sys_src <= cur_sel.src_eff;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_sys_div <= 10'h000;
		end else if (!cur_sel.div_rsv) begin
			o_sys_div <= cur_sel.div_onehot;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_fast_internal_freq_select <= 4'h0;
		end else begin
			o_fast_internal_freq_select <= internal_freq_reg_r[3:0];
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_external_mode <= 3'h0;
		end else begin
			o_external_mode <= i_external_osc_mode_cfg;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_secondary_osc_power <= 1'b0;
		end else begin
			o_secondary_osc_power <= secondary_osc_power_r;
		end
	end

	// ------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------
	// Level only, software clears it by reading interrupt status
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_stat_r & irq_mask_r);
		end
	end
endmodule // oscsw_top

// ===== verif/oscsw_chk.sv
`include "oscsw_defs.svh"

module oscsw_chk (
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] i_osc_ready,
	input wire logic [2:0] i_external_osc_mode_cfg,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_osc_enable,
	input wire logic [2:0] o_sys_src,
	input wire logic [9:0] o_sys_div,
	input wire logic [3:0] o_fast_internal_freq_select,
	input wire logic [2:0] o_external_mode,
	input wire logic       o_secondary_osc_power,
	input wire logic       o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// Checks
	// ----------------
	// Outputs sit at zero until the internal reset copy lets go
	logic [2:0] up_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			up_r <= 3'h0;
		else if (up_r != 3'h7)
			up_r <= up_r + 3'h1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_STAT_RSV: assert property (
		$past(i_rd && i_addr == `OSCSW_ADDR_STAT) |-> o_rdata[5] == 1'b0 && o_rdata[2:0] == 3'h0)
		else $error("status spare bits set");
	AST_FREQ_HI: assert property (
		$past(i_rd && i_addr == `OSCSW_ADDR_FREQ) |-> o_rdata[7:4] == 4'h0)
		else $error("freq upper nibble set");
	AST_DONE_NEWRDY: assert property (
		$past(i_rd && i_addr == `OSCSW_ADDR_STAT) && o_rdata[4] |-> !o_rdata[3])
		else $error("new ready with no switch");
	AST_SRC_EFF: assert property (
		up_r == 3'h7 |-> o_sys_src != 3'h0 && o_sys_src != 3'h3)
		else $error("reserved source on output");
	AST_PWR: assert property (
		i_wr && i_addr == `OSCSW_ADDR_STAT |-> ##2 o_secondary_osc_power == $past(i_wdata[6], 2))
		else $error("power mode not applied");
	AST_EXT: assert property (
		up_r == 3'h7 |-> o_external_mode == $past(i_external_osc_mode_cfg))
		else $error("external mode mismatch");
	AST_IRQ_OFF: assert property (
		i_wr && i_addr == `OSCSW_ADDR_IRQ_MASK && i_wdata == 8'h00 |-> ##2 !o_irq [*2])
		else $error("irq with full mask");
	AST_UNMAP: assert property (
		$past(i_rd && i_addr > `OSCSW_ADDR_IRQ_MASK) |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");

	cover property (o_irq);
	cover property ($past(i_rd && i_addr == `OSCSW_ADDR_STAT) && o_rdata[3]);
	cover property (up_r == 3'h7 && $changed(o_sys_src));
endmodule // oscsw_chk

bind oscsw_top oscsw_chk oscsw_chk_inst (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
	.i_osc_ready, .i_external_osc_mode_cfg, .o_rdata, .o_osc_enable, .o_sys_src, .o_sys_div,
	.o_fast_internal_freq_select, .o_external_mode, .o_secondary_osc_power, .o_irq);

// ===== verif/test_oscillator_switch_control.sv
`include "oscsw_defs.svh"

module test_oscillator_switch_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clk, i_rst_n, i_wr, i_rd, o_secondary_osc_power, o_irq;
	logic [3:0] i_addr, o_fast_internal_freq_select;
	logic [7:0] i_wdata, i_osc_ready, o_rdata, o_osc_enable;
	logic [2:0] i_external_osc_mode_cfg, o_sys_src, o_external_mode;
	logic [9:0] o_sys_div;
	int         miscompares = 0;
	int         compares = 0;

	oscsw_top oscsw_top_inst (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.i_osc_ready, .i_external_osc_mode_cfg, .o_rdata, .o_osc_enable, .o_sys_src,
		.o_sys_div, .o_fast_internal_freq_select, .o_external_mode,
		.o_secondary_osc_power, .o_irq);

	// ----------------
	// Bus and compare
	// ----------------
	task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", o_rdata, e);
	endtask
	// Walk puts derived outputs two edges after the request is latched
	task automatic settle;
		repeat (4) @(posedge i_clk);
		#1;
	endtask

	task automatic t_reset;
		rchk(`OSCSW_ADDR_REQ, 8'h00);
		rchk(`OSCSW_ADDR_STAT, 8'h10);
		chk("src", o_sys_src, 3'h6);
		$display("test reset done");
	endtask
	task automatic t_switch;
		logic [7:0] v;
		wr(`OSCSW_ADDR_IRQ_MASK, 8'h02);
		for (int i = 1; i <= 8; i++) begin
			v = {1'b0, 3'(i), (i == 8) ? 4'h9 : 4'(i)};
			wr(`OSCSW_ADDR_REQ, v);
			settle();
			chk("src", o_sys_src, (v[6:4] == 3'h0 || v[6:4] == 3'h3) ? 3'h6 : v[6:4]);
			chk("div", o_sys_div, 10'h1 << v[3:0]);
			chk("irq", o_irq, 1'b1);
			rchk(`OSCSW_ADDR_CUR, v);
			rchk(`OSCSW_ADDR_STAT, 8'h10);
			rchk(`OSCSW_ADDR_IRQ_STAT, 8'h02);
			repeat (2) @(posedge i_clk);
			#1 chk("irq", o_irq, 1'b0);
		end
		wr(`OSCSW_ADDR_REQ, 8'h6a);
		settle();
		chk("div", o_sys_div, 10'h200);
		rchk(`OSCSW_ADDR_CUR, 8'h6a);
		rchk(`OSCSW_ADDR_IRQ_STAT, 8'h02);
		$display("test switch done");
	endtask
	task automatic t_hold;
		i_osc_ready <= 8'h00;
		wr(`OSCSW_ADDR_STAT, 8'h80);
		wr(`OSCSW_ADDR_IRQ_MASK, 8'h01);
		wr(`OSCSW_ADDR_REQ, 8'h45);
		settle();
		rchk(`OSCSW_ADDR_STAT, 8'h80);
		i_osc_ready <= 8'h10;
		settle();
		rchk(`OSCSW_ADDR_STAT, 8'h88);
		chk("src", o_sys_src, 3'h6);
		chk("osc_en", o_osc_enable, 8'h50);
		chk("irq", o_irq, 1'b1);
		rchk(`OSCSW_ADDR_IRQ_STAT, 8'h01);
		wr(`OSCSW_ADDR_STAT, 8'h00);
		settle();
		chk("src", o_sys_src, 3'h4);
		rchk(`OSCSW_ADDR_STAT, 8'h10);
		wr(`OSCSW_ADDR_IRQ_MASK, 8'h02);
		settle();
		chk("irq", o_irq, 1'b1);
		wr(`OSCSW_ADDR_IRQ_MASK, 8'h00);
		settle();
		chk("irq", o_irq, 1'b0);
		$display("test hold done");
	endtask
	task automatic t_regs;
		wr(`OSCSW_ADDR_STAT, 8'h7f);
		rchk(`OSCSW_ADDR_STAT, 8'h50);
		chk("pwr", o_secondary_osc_power, 1'b1);
		wr(`OSCSW_ADDR_STAT, 8'h00);
		wr(`OSCSW_ADDR_FREQ, 8'hab);
		rchk(`OSCSW_ADDR_FREQ, 8'h0b);
		chk("freq", o_fast_internal_freq_select, 4'hb);
		wr(`OSCSW_ADDR_CUR, 8'h11);
		rchk(`OSCSW_ADDR_CUR, 8'h45);
		wr(4'hf, 8'hff);
		rchk(4'hf, 8'h00);
		i_external_osc_mode_cfg <= 3'h5;
		settle();
		chk("ext", o_external_mode, 3'h5);
		$display("test regs done");
	endtask

	task automatic tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		#100us;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_osc_ready = 8'hff;
		i_external_osc_mode_cfg = 3'h2;
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		t_reset();
		t_switch();
		t_hold();
		t_regs();
		tally_and_finish();
	end
endmodule // test_oscillator_switch_control
